// *** core_model.sv ***
// Behavioural processor core facing the controller
`timescale 1ns/100ps
`default_nettype none

module core_model
(
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    // Controller side
    input wire irq_request,
    input wire [15:0] irq_vector,
    output logic irq_accept,
    output logic return_done,
    output logic instr_done,
    // Bench control
    input wire take,
    input wire ret,
    output logic [15:0] vec_seen
);
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            irq_accept <= 1'b0;
            return_done <= 1'b0;
            instr_done <= 1'b0;
            vec_seen <= 16'h0000;
        end
        else
        begin
            // Finish instruction, push and jump; never two accepts in a row
            irq_accept <= take && irq_request && !irq_accept;
            if (irq_accept && irq_request)
                vec_seen <= irq_vector;
            return_done <= ret;
            // No instruction retires in the return cycle
            instr_done <= !ret;
        end
    end
endmodule // core_model
`default_nettype wire

// *** irq_ctrl.v ***
// Two-level vectored interrupt controller with APB register access
`timescale 1ns/100ps
`default_nettype none
`include "irq_ctrl_defs.vh"

module irq_ctrl
(
    // Clock and reset
    input wire sys_clk,
    input wire reset,

    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output reg pslverr,

    // Source events, one-cycle pulses indexed by query number
    input wire [`NUM_SRC-1:0] src_event,

    // Core handshake
    input wire instr_done,
    input wire irq_accept,
    input wire return_done,
    output reg irq_request,
    output reg [15:0] irq_vector,

    // Summary interrupt
    output wire irq_out
);

    // ==========================================
    // Software-visible state
    reg [`PRIM_W-1:0] en_prim_q;
    reg global_irq_enable_q;
    reg [`SEC_W-1:0] en_sec_q;
    reg [`PRIM_W-1:0] prio_prim_q;
    reg [`SEC_W-1:0] prio_sec_q;
    reg [`NUM_SRC-1:0] flag_q;
    reg [`NUM_SRC-1:0] flag_d;
    reg [`NUM_SRC-1:0] mask_q;

    // ==========================================
    // Core-facing state
    reg [1:0] in_service_q;
    reg [1:0] in_service_d;
    reg return_hold_q;
    reg [3:0] grant_idx_q;
    reg grant_lvl_q;

    // ==========================================
    // Register decode
    function [2:0] reg_sel;
        input [9:0] index;
        begin
            case (index)
                `IDX_ENABLE_PRIMARY: reg_sel = 3'h1;
                `IDX_ENABLE_SECONDARY: reg_sel = 3'h2;
                `IDX_PRIORITY_PRIMARY: reg_sel = 3'h3;
                `IDX_PRIORITY_SECONDARY: reg_sel = 3'h4;
                `IDX_FLAG_STATUS: reg_sel = 3'h5;
                `IDX_FLAG_MASK: reg_sel = 3'h6;
                `IDX_CORE_STATE: reg_sel = 3'h7;
                default: reg_sel = 3'h0;
            endcase
        end
    endfunction

    localparam [2:0] SEL_NONE = 3'h0;
    localparam [2:0] SEL_EN_PRIM = 3'h1;
    localparam [2:0] SEL_EN_SEC = 3'h2;
    localparam [2:0] SEL_PRIO_PRIM = 3'h3;
    localparam [2:0] SEL_PRIO_SEC = 3'h4;
    localparam [2:0] SEL_STATUS = 3'h5;
    localparam [2:0] SEL_MASK = 3'h6;
    localparam [2:0] SEL_STATE = 3'h7;

    wire [2:0] sel;
    wire setup_phase;
    wire wr_en;

    // Zero wait states; read data is captured in the setup cycle
    assign pready = 1'b1;
    assign sel = reg_sel(paddr[11:2]);
    assign setup_phase = psel & ~penable;
    assign wr_en = psel & penable & pwrite & (sel != SEL_NONE);

    // ==========================================
    // Request qualification
    wire [`NUM_SRC-1:0] enable_all;
    wire [`NUM_SRC-1:0] high_sel;
    wire [`NUM_SRC-1:0] armed;
    wire [`NUM_SRC-1:0] hi_cand;
    wire [`NUM_SRC-1:0] lo_cand;
    wire hi_valid;
    wire lo_valid;
    wire [3:0] hi_idx;
    wire [3:0] lo_idx;

    // Query-number order lines up with the register bit order
    assign enable_all = {en_sec_q, en_prim_q};
    assign high_sel = {prio_sec_q, prio_prim_q};
    assign armed = flag_q & enable_all & {`NUM_SRC{global_irq_enable_q}};
    assign hi_cand = armed & high_sel;
    assign lo_cand = armed & ~high_sel;

    irq_pick u_pick_hi
    (
        .req(hi_cand),
        .valid(hi_valid),
        .idx(hi_idx)
    );

    irq_pick u_pick_lo
    (
        .req(lo_cand),
        .valid(lo_valid),
        .idx(lo_idx)
    );

    // ==========================================
    // Level arbitration
    reg win_valid;
    reg win_lvl;
    reg [3:0] win_idx;

    always @*
    begin
        win_valid = 1'b0;
        win_lvl = 1'b0;
        win_idx = hi_idx;
        if (in_service_q[`LVL_HI])
        begin
            // Nothing may break into a high routine
            win_valid = 1'b0;
        end
        else if (hi_valid)
        begin
            win_valid = 1'b1;
            win_lvl = 1'b1;
        end
        else if (lo_valid && !in_service_q[`LVL_LO])
        begin
            win_valid = 1'b1;
            win_idx = lo_idx;
        end
    end

    // Accept is honoured only against the request that was shown
    wire accept_ok;
    assign accept_ok = irq_accept & irq_request;

    // ==========================================
    // Request and vector outputs
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            irq_request <= 1'b0;
            irq_vector <= `VECTOR_BASE;
            grant_idx_q <= 4'h0;
            grant_lvl_q <= 1'b0;
        end
        else
        begin
            // Drop for a cycle after accept so the marker settles first
            irq_request <= win_valid & ~accept_ok & ~return_hold_q & ~return_done;
            irq_vector <= `VECTOR_BASE + {8'h00, win_idx, 3'b000};
            grant_idx_q <= win_idx;
            grant_lvl_q <= win_lvl;
        end
    end

    // ==========================================
    // Return tracking
    always @*
    begin
        in_service_d = in_service_q;
        if (return_done)
        begin
            if (in_service_q[`LVL_HI])
                in_service_d[`LVL_HI] = 1'b0;
            else
                in_service_d[`LVL_LO] = 1'b0;
        end
        if (accept_ok)
            in_service_d[grant_lvl_q] = 1'b1;
    end

    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            in_service_q <= 2'b00;
            return_hold_q <= 1'b0;
        end
        else
        begin
            in_service_q <= in_service_d;
            // The return itself does not count as the extra instruction
            if (return_done)
                return_hold_q <= 1'b1;
            else if (instr_done)
                return_hold_q <= 1'b0;
        end
    end

    // ==========================================
    // Request flags
    reg [`NUM_SRC-1:0] auto_clr;
    reg [`NUM_SRC-1:0] sw_clr;
    wire [`NUM_SRC-1:0] hw_clear_mask;

    assign hw_clear_mask = `HW_CLEAR_MASK;

    always @*
    begin
        auto_clr = `RST_SRC;
        if (accept_ok)
            auto_clr[grant_idx_q] = hw_clear_mask[grant_idx_q];
        sw_clr = `RST_SRC;
        if (wr_en && sel == SEL_STATUS)
            sw_clr = pwdata[`NUM_SRC-1:0];
        // A new event beats any clear in the same cycle
        flag_d = (flag_q & ~(auto_clr | sw_clr)) | src_event;
    end

    always @(posedge sys_clk)
    begin
        if (reset)
            flag_q <= `RST_SRC;
        else
            flag_q <= flag_d;
    end

    assign irq_out = |(flag_q & mask_q);

    // ==========================================
    // Register writes
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            global_irq_enable_q <= 1'b0;
            en_prim_q <= `RST_PRIM;
            en_sec_q <= `RST_SEC;
            prio_prim_q <= `RST_PRIM;
            prio_sec_q <= `RST_SEC;
            mask_q <= `RST_SRC;
        end
        else if (wr_en)
        begin
            case (sel)
                SEL_EN_PRIM:
                begin
                    global_irq_enable_q <= pwdata[`GLOBAL_EN_BIT];
                    en_prim_q <= pwdata[`PRIM_W-1:0];
                end
                SEL_EN_SEC: en_sec_q <= pwdata[`SEC_W-1:0];
                SEL_PRIO_PRIM: prio_prim_q <= pwdata[`PRIM_W-1:0];
                SEL_PRIO_SEC: prio_sec_q <= pwdata[`SEC_W-1:0];
                SEL_MASK: mask_q <= pwdata[`NUM_SRC-1:0];
                default: mask_q <= mask_q;
            endcase
        end
    end

    // ==========================================
    // Register reads
    reg [31:0] rd_mux;

    always @*
    begin
        rd_mux = 32'h0000_0000;
        case (sel)
            SEL_EN_PRIM: rd_mux = {24'h000000, global_irq_enable_q, en_prim_q};
            SEL_EN_SEC: rd_mux = {27'h0000000, en_sec_q};
            SEL_PRIO_PRIM: rd_mux = {25'h0000000, prio_prim_q};
            SEL_PRIO_SEC: rd_mux = {27'h0000000, prio_sec_q};
            SEL_STATUS: rd_mux = {20'h00000, flag_q};
            SEL_MASK: rd_mux = {20'h00000, mask_q};
            SEL_STATE: rd_mux = {23'h000000, grant_idx_q, irq_request, return_hold_q, grant_lvl_q, in_service_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (setup_phase)
        begin
            prdata <= rd_mux;
            pslverr <= (sel == SEL_NONE);
        end
    end

endmodule // irq_ctrl
`default_nettype wire

// *** irq_ctrl_defs.vh ***
// Constants for the two-level interrupt controller
`ifndef IRQ_CTRL_DEFS_VH
`define IRQ_CTRL_DEFS_VH

// ==========================================
// Register indices (byte address is four times the index)
`define IDX_ENABLE_PRIMARY 10'h0a8
`define IDX_ENABLE_SECONDARY 10'h0a9
`define IDX_PRIORITY_PRIMARY 10'h0b8
`define IDX_PRIORITY_SECONDARY 10'h0b9
`define IDX_FLAG_STATUS 10'h0c0
`define IDX_FLAG_MASK 10'h0c1
`define IDX_CORE_STATE 10'h0c2

// ==========================================
// Field layout
`define NUM_SRC 12
`define GLOBAL_EN_BIT 7
`define PRIM_W 7
`define SEC_W 5
`define SRC_PWM 4'h8
`define HW_CLEAR_MASK 12'hb0f
`define VECTOR_BASE 16'h0003
`define LVL_LO 0
`define LVL_HI 1

// ==========================================
// Reset values
`define RST_PRIM 7'h00
`define RST_SEC 5'h00
`define RST_SRC 12'h000

`endif

// *** irq_ctrl_sva.sv ***
// Port checker for the interrupt controller
`timescale 1ns/100ps
`default_nettype none
`include "irq_ctrl_defs.vh"

module irq_ctrl_chk
(
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire [31:0] prdata,
    input wire pslverr,
    // Sources and core
    input wire [`NUM_SRC-1:0] src_event,
    input wire instr_done,
    input wire irq_accept,
    input wire return_done,
    input wire irq_request,
    input wire [15:0] irq_vector,
    input wire irq_out
);
    // ==========================================
    // Helper state
    wire [9:0] idx = paddr[11:2];
    wire mapped = idx == 10'h0a8 || idx == 10'h0a9 || idx == 10'h0b8 || idx == 10'h0b9
        || (idx >= 10'h0c0 && idx <= 10'h0c2);
    wire setup = psel && !penable;
    reg global_en_q;

    always @(posedge sys_clk)
    begin
        if (reset)
            global_en_q <= 1'b0;
        else if (psel && penable && pwrite && idx == 10'h0a8)
            global_en_q <= pwdata[7];
    end

    // ==========================================
    // Properties
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    a_vector_in_table: assert property (irq_request |-> irq_vector[2:0] == 3'h3 && irq_vector <= 16'h005b)
        else $error("vector off table");
    a_accept_drops_req: assert property (irq_accept && irq_request |=> !irq_request)
        else $error("request held after accept");
    a_return_hold: assert property (return_done |=> !irq_request)
        else $error("request right after return");
    a_global_gate: assert property (!global_en_q |=> !irq_request)
        else $error("request with global enable off");
    a_unmapped_err: assert property (setup && !mapped |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_prio_reserved: assert property (setup && !pwrite && idx == 10'h0b8 |=> prdata[31:7] == 25'h0)
        else $error("priority reserved bits set");
    a_sec_reserved: assert property (setup && !pwrite && idx == 10'h0a9 |=> prdata[31:5] == 27'h0)
        else $error("secondary enable reserved bits set");
    a_reset_idle: assert property ($fell(reset) |-> !irq_request && irq_vector == 16'h0003)
        else $error("not idle after reset");

    c_accept: cover property (irq_accept && irq_request);
    c_return: cover property (return_done);
    c_summary: cover property (irq_out);
endmodule // irq_ctrl_chk

bind irq_ctrl irq_ctrl_chk chk (.*);
`default_nettype wire

// *** irq_pick.v ***
// Lowest-index request picker for one priority level
`timescale 1ns/100ps
`default_nettype none
`include "irq_ctrl_defs.vh"

module irq_pick
(
    // Candidate requests
    input wire [`NUM_SRC-1:0] req,
    // Winner
    output reg valid,
    output reg [3:0] idx
);

    integer i;

    // Walk downward so the smallest set index is the last one written
    always @*
    begin
        valid = 1'b0;
        idx = 4'h0;
        for (i = `NUM_SRC - 1; i >= 0; i = i - 1)
        begin
            if (req[i])
            begin
                valid = 1'b1;
                idx = i[3:0];
            end
        end
    end

endmodule // irq_pick
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the interrupt controller
`timescale 1ns/100ps
`default_nettype none

module tb;
    logic sys_clk, reset, psel, penable, pwrite, take, ret, pslverr, err;
    logic [11:0] paddr, src_event;
    logic [31:0] pwdata, prdata, rd;
    wire pready, instr_done, irq_accept, return_done, irq_request, irq_out;
    logic [15:0] irq_vector, vec_seen;
    int fail_count, tests_run;

    irq_ctrl dut (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .src_event(src_event), .instr_done(instr_done), .irq_accept(irq_accept), .return_done(return_done),
        .irq_request(irq_request), .irq_vector(irq_vector), .irq_out(irq_out));
    core_model core (.sys_clk(sys_clk), .reset(reset), .irq_request(irq_request), .irq_vector(irq_vector),
        .irq_accept(irq_accept), .return_done(return_done), .instr_done(instr_done), .take(take), .ret(ret),
        .vec_seen(vec_seen));

    always #2 sys_clk = ~sys_clk;

    // ==========================================
    // Shared tasks
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next call never reassigns psel in this step
        @(posedge sys_clk);
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask

    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task pulse(input logic [11:0] m, input int n);
        src_event <= m;
        @(posedge sys_clk);
        src_event <= 12'h000;
        repeat (n) @(posedge sys_clk);
    endtask

    task do_return;
        ret <= 1'b1;
        @(posedge sys_clk);
        ret <= 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask

    task summarize;
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task t_reset;
        rdchk(12'h2a0, 32'h0);
        rdchk(12'h2a4, 32'h0);
        rdchk(12'h2e0, 32'h0);
        rdchk(12'h3fc, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask

    task t_regs;
        apb(1'b1, 12'h2e0, 32'hff);
        rdchk(12'h2e0, 32'h7f);
        apb(1'b1, 12'h2a4, 32'hff);
        rdchk(12'h2a4, 32'h1f);
        apb(1'b1, 12'h2e0, 32'h0);
        apb(1'b1, 12'h2a0, 32'hff);
        rdchk(12'h2a0, 32'hff);
    endtask

    task t_nesting;
        pulse(12'h01a, 2);
        chk({irq_request, irq_vector}, {1'b1, 16'h000b});
        take <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk({irq_request, vec_seen}, {1'b0, 16'h000b});
        apb(1'b1, 12'h2e0, 32'h08);
        repeat (6) @(posedge sys_clk);
        chk(vec_seen, 16'h001b);
        do_return();
        chk({irq_request, vec_seen}, {1'b0, 16'h001b});
        do_return();
        chk(vec_seen, 16'h0023);
        rdchk(12'h300, 32'h010);
        apb(1'b1, 12'h300, 32'h010);
        do_return();
        chk({irq_request, vec_seen}, {1'b0, 16'h0023});
    endtask

    task t_gate;
        apb(1'b1, 12'h2a0, 32'h7f);
        pulse(12'h001, 4);
        chk({irq_request, vec_seen}, {1'b0, 16'h0023});
        apb(1'b1, 12'h304, 32'h001);
        @(posedge sys_clk);
        chk(irq_out, 1'b1);
        apb(1'b1, 12'h300, 32'h001);
        @(posedge sys_clk);
        chk(irq_out, 1'b0);
        apb(1'b1, 12'h2a0, 32'hff);
        pulse(12'h100, 6);
        chk(vec_seen, 16'h0043);
        do_return();
    endtask

    initial
    begin
        sys_clk = 1'b0;
        reset = 1'b1;
        {psel, penable, pwrite, take, ret} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        src_event = 12'h000;
        fail_count = 0;
        tests_run = 0;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        t_reset();
        t_regs();
        t_nesting();
        t_gate();
        summarize();
    end

    // Whole run needs a few hundred cycles at most
    initial
    begin
        #40000;
        fail_count++;
        summarize();
    end
endmodule // tb
`default_nettype wire
